// [rtl/pdb_bridge.sv]
// both halves of the power domain crossing bridge
// assumes slave side on clk/reset_n, master side on m_clk/m_reset_n,
// and a power controller pin that is asynchronous to clk
`timescale 1ns/1ps
module pdb_bridge
    import pdb_pkg::*;
(
    // slave-side half, facing the master
    input  wire logic     clk,
    input  wire logic     reset_n,
    input  wire logic     s_req_valid,
    input  wire pdb_req_t s_req,
    output logic          s_req_ready,
    output logic          s_rsp_valid,
    output pdb_rsp_t      s_rsp,
    input  wire logic     s_rsp_ready,
    // platform_power_controller handshake
    input  wire logic     pdn_req,
    output logic          pdn_ack,
    // master-side half, facing the slave
    input  wire logic     m_clk,
    input  wire logic     m_reset_n,
    output logic          m_req_valid,
    output pdb_req_t      m_req,
    input  wire logic     m_req_ready,
    input  wire logic     m_rsp_valid,
    input  wire pdb_rsp_t m_rsp,
    output logic          m_rsp_ready
);
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_RESP} pdb_sst_t;
    typedef enum logic [1:0] {M_IDLE, M_REQ, M_RSP} pdb_mst_t;

    pdb_sst_t         s_st;        // slave-side state
    pdb_mst_t         m_st;        // master-side state
    logic             s_tgl;       // flips once per forwarded request
    logic             m_tgl;       // follows s_tgl when the answer is held
    logic             m_sync1;     // m_tgl into clk, first stage
    logic             m_sync2;     // m_tgl into clk, second stage
    logic             s_sync1;     // s_tgl into m_clk, first stage
    logic             s_sync2;     // s_tgl into m_clk, second stage
    logic             p_sync1;     // power request, first stage
    logic             p_sync2;     // power request, second stage
    logic             held;        // power-down request captured
    logic             rsp_fwd;     // current answer came from the far side
    logic [CNT_W-1:0] cnt;         // outstanding transactions
    pdb_rsp_t         m_hold;      // answer held for the crossing
    logic             accept;      // request taken this cycle

    assign accept = s_req_valid && s_req_ready;

    // synchronisers into clk
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            m_sync1 <= RST_BIT;
            m_sync2 <= RST_BIT;
            p_sync1 <= RST_BIT;
            p_sync2 <= RST_BIT;
        end else begin
            m_sync1 <= m_tgl;
            m_sync2 <= m_sync1;
            p_sync1 <= pdn_req;
            p_sync2 <= p_sync1;
        end
    end

    // slave-side transaction sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_st        <= S_IDLE;
            s_tgl       <= RST_BIT;
            s_req_ready <= RST_BIT;
            s_rsp_valid <= RST_BIT;
            s_rsp       <= RSP_RST;
            m_req       <= REQ_RST;
            rsp_fwd     <= RST_BIT;
        end else begin
            case (s_st)
                S_IDLE: begin
                    s_req_ready <= 1'b1;
                    if (accept) begin
                        s_req_ready <= 1'b0;
                        if (held) begin
                            // refuse without touching the far side
                            s_rsp       <= RSP_ERROR;
                            s_rsp_valid <= 1'b1;
                            rsp_fwd     <= 1'b0;
                            s_st        <= S_RESP;
                        end else begin
                            // data held stable until the toggle returns
                            m_req   <= s_req;
                            s_tgl   <= ~s_tgl;
                            rsp_fwd <= 1'b1;
                            s_st    <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    // open transaction finishes even while held
                    if (m_sync2 == s_tgl) begin
                        s_rsp       <= m_hold;
                        s_rsp_valid <= 1'b1;
                        s_st        <= S_RESP;
                    end
                end
                S_RESP: begin
                    if (s_rsp_ready) begin
                        s_rsp_valid <= 1'b0;
                        s_st        <= S_IDLE;
                    end
                end
                default: s_st <= S_IDLE;
            endcase
        end
    end

    // outstanding transaction counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= RST_CNT;
        end else if (accept && !held) begin
            cnt <= cnt + CNT_ONE;
        end else if (s_st == S_RESP && s_rsp_ready && rsp_fwd) begin
            cnt <= cnt - CNT_ONE;
        end
    end

    // power-down capture and acknowledge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held    <= RST_BIT;
            pdn_ack <= RST_BIT;
        end else begin
            if (p_sync2) begin
                held <= 1'b1;
            end else if (pdn_ack) begin
                held <= 1'b0;
            end
            // ack once drained, dropped only after withdrawal
            // an early withdrawal still gets a one-cycle ack so held can clear
            if (held && (p_sync2 || !pdn_ack) && cnt == RST_CNT && s_st == S_IDLE) begin
                pdn_ack <= 1'b1;
            end else if (!p_sync2) begin
                pdn_ack <= 1'b0;
            end
        end
    end

    // synchroniser into m_clk
    always_ff @(posedge m_clk or negedge m_reset_n) begin
        if (!m_reset_n) begin
            s_sync1 <= RST_BIT;
            s_sync2 <= RST_BIT;
        end else begin
            s_sync1 <= s_tgl;
            s_sync2 <= s_sync1;
        end
    end

    // master-side half, own clock and reset
    always_ff @(posedge m_clk or negedge m_reset_n) begin
        if (!m_reset_n) begin
            m_st        <= M_IDLE;
            m_tgl       <= RST_BIT;
            m_req_valid <= RST_BIT;
            m_rsp_ready <= RST_BIT;
            m_hold      <= RSP_RST;
        end else begin
            case (m_st)
                M_IDLE: begin
                    if (s_sync2 != m_tgl) begin
                        m_req_valid <= 1'b1;
                        m_st        <= M_REQ;
                    end
                end
                M_REQ: begin
                    if (m_req_ready) begin
                        m_req_valid <= 1'b0;
                        m_rsp_ready <= 1'b1;
                        m_st        <= M_RSP;
                    end
                end
                M_RSP: begin
                    if (m_rsp_valid) begin
                        m_rsp_ready <= 1'b0;
                        m_hold      <= m_rsp;
                        m_tgl       <= s_sync2;   // hands the answer back
                        m_st        <= M_IDLE;
                    end
                end
                default: m_st <= M_IDLE;
            endcase
        end
    end

    // checks on the slave-side half and the master-side half
    AST_ERR_WHILE_HELD: assert property (@(posedge clk) disable iff (!reset_n)
        accept && held |=> s_rsp_valid && s_rsp.resp == RESP_SLVERR && s_rsp.rdata == '0)
        else $error("held request not answered with error");
    AST_NO_FWD_WHILE_HELD: assert property (@(posedge clk) disable iff (!reset_n)
        accept && held |=> $stable(s_tgl) && cnt == $past(cnt))
        else $error("request forwarded while held");
    AST_CNT_UP: assert property (@(posedge clk) disable iff (!reset_n)
        accept && !held |=> cnt == $past(cnt) + CNT_ONE && s_tgl != $past(s_tgl))
        else $error("forwarded request not counted");
    AST_ACK_DRAINED: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(pdn_ack) |-> $past(cnt) == RST_CNT && $past(held) && $past(s_st) == S_IDLE)
        else $error("ack while transactions open");
    AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        pdn_ack && p_sync2 |=> pdn_ack)
        else $error("ack dropped before withdrawal");
    AST_HELD_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
        held && !pdn_ack |=> held)
        else $error("power-down request lost");
    AST_ACK_TIMELY: assert property (@(posedge clk) disable iff (!reset_n)
        held && p_sync2 && cnt == RST_CNT && s_st == S_IDLE |=> pdn_ack)
        else $error("drained but no ack");
    AST_OPEN_COMPLETES: assert property (@(posedge clk) disable iff (!reset_n)
        s_st == S_WAIT && m_sync2 == s_tgl |=> s_rsp_valid && s_rsp == $past(m_hold))
        else $error("open transaction not completed");
    AST_FAR_ISSUE: assert property (@(posedge m_clk) disable iff (!m_reset_n)
        m_st == M_IDLE && s_sync2 != m_tgl |=> m_req_valid)
        else $error("crossed request not issued");

    COV_REJECT: cover property (@(posedge clk) disable iff (!reset_n) accept && held);
    COV_FORWARD: cover property (@(posedge clk) disable iff (!reset_n)
        s_rsp_valid && s_rsp_ready && rsp_fwd);
    COV_ACK: cover property (@(posedge clk) disable iff (!reset_n) $rose(pdn_ack));
    COV_DRAIN: cover property (@(posedge clk) disable iff (!reset_n)
        held && cnt != RST_CNT ##[1:200] pdn_ack);
endmodule

// [common/pdb_pkg.sv]
// constants and carriers for the power domain crossing bridge
// assumes a simple valid/ready request and response bus on both sides
package pdb_pkg;
    localparam int unsigned ADDR_W = 32;          // bus address width
    localparam int unsigned DATA_W = 32;          // bus data width
    localparam int unsigned CNT_W  = 4;           // outstanding counter width

    // response codes on the bus
    localparam logic [1:0] RESP_OKAY   = 2'h0;    // normal completion
    localparam logic [1:0] RESP_SLVERR = 2'h2;    // slave error

    // reset values and counter step
    localparam logic             RST_BIT = 1'h0;  // any control flag
    localparam logic [CNT_W-1:0] RST_CNT = 4'h0;  // outstanding count
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;  // counter step

    // one request travelling from master to slave
    typedef struct packed {
        logic [ADDR_W-1:0] addr;   // target address
        logic              write;  // 1 write, 0 read
        logic [DATA_W-1:0] wdata;  // write data
    } pdb_req_t;

    // one response travelling back
    typedef struct packed {
        logic [DATA_W-1:0] rdata;  // read data
        logic [1:0]        resp;   // response code
    } pdb_rsp_t;

    localparam pdb_rsp_t RSP_ERROR = '{rdata: '0, resp: RESP_SLVERR}; // rejection answer
    localparam pdb_req_t REQ_RST   = '{addr: '0, write: 1'b0, wdata: '0};
    localparam pdb_rsp_t RSP_RST   = '{rdata: '0, resp: RESP_OKAY};
endpackage

// [sim/pdb_far_slave.sv]
// far slave model on the master-side bus of the bridge
// assumes one request at a time, driven at falling m_clk
`timescale 1ns/1ps
module pdb_far_slave
    import pdb_pkg::*;
(
    // far bus
    input  wire logic     m_clk,
    input  wire logic     m_req_valid,
    input  wire pdb_req_t m_req,
    output logic          m_req_ready,
    output logic          m_rsp_valid,
    output pdb_rsp_t      m_rsp,
    input  wire logic     m_rsp_ready,
    // answer delay in m_clk cycles
    input  wire logic [31:0] lat
);
    logic [DATA_W-1:0] mem;   // one word store
    int                n;     // bounded wait count
    // take, wait, answer, then show stale inverted payload
    initial begin
        m_req_ready = 0;
        m_rsp_valid = 0;
        m_rsp = '0;
        mem = '0;
        forever begin
            @(negedge m_clk);
            if (m_req_valid === 1'b1) begin
                m_req_ready = 1;
                if (m_req.write) mem = m_req.wdata;
                m_rsp = '{rdata: m_req.write ? '0 : mem, resp: RESP_OKAY};
                @(negedge m_clk);
                m_req_ready = 0;
                repeat (lat) @(negedge m_clk);
                m_rsp_valid = 1;
                n = 0;
                while (m_rsp_ready !== 1'b1 && n < 300) begin
                    @(negedge m_clk);
                    n++;
                end
                @(negedge m_clk);
                m_rsp_valid = 0;
                m_rsp = ~m_rsp;
            end
        end
    end
endmodule

// [sim/pdb_bridge_tb_top.sv]
// self-checking bench for the power domain crossing bridge
// assumes the far slave model on the master side
`timescale 1ns/1ps
module pdb_bridge_tb_top;
    import pdb_pkg::*;
    logic     clk, reset_n, m_clk, m_reset_n, pdn_req, pdn_ack;
    logic     s_req_valid, s_req_ready, s_rsp_valid, s_rsp_ready;
    logic     m_req_valid, m_req_ready, m_rsp_valid, m_rsp_ready;
    pdb_req_t s_req, m_req;
    pdb_rsp_t s_rsp, m_rsp, r;
    int       errors, samples_checked, lat, fwd, f0;
    // two unrelated clocks
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        m_clk = 0;
        forever #7 m_clk = ~m_clk;
    end
    // count requests reaching the far side
    always @(posedge m_clk) if (m_req_valid && m_req_ready) fwd++;
    pdb_bridge dut_u (.clk(clk), .reset_n(reset_n), .s_req_valid(s_req_valid),
        .s_req(s_req), .s_req_ready(s_req_ready), .s_rsp_valid(s_rsp_valid),
        .s_rsp(s_rsp), .s_rsp_ready(s_rsp_ready), .pdn_req(pdn_req), .pdn_ack(pdn_ack),
        .m_clk(m_clk), .m_reset_n(m_reset_n), .m_req_valid(m_req_valid), .m_req(m_req),
        .m_req_ready(m_req_ready), .m_rsp_valid(m_rsp_valid), .m_rsp(m_rsp),
        .m_rsp_ready(m_rsp_ready));
    pdb_far_slave far_u (.m_clk(m_clk), .m_req_valid(m_req_valid), .m_req(m_req),
        .m_req_ready(m_req_ready), .m_rsp_valid(m_rsp_valid), .m_rsp(m_rsp),
        .m_rsp_ready(m_rsp_ready), .lat(lat));
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // bounded wait for a level, checked at falling edges
    task automatic wait_for(ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl) begin
            @(negedge clk);
            n++;
            if (n > 200) begin
                chk("wait level", sig, lvl);
                close_out();
            end
        end
    endtask
    // one whole request and response on the slave bus
    task automatic xfer(input logic wr, input logic [31:0] a, d);
        @(negedge clk);
        s_req = '{addr: a, write: wr, wdata: d};
        s_req_valid = 1;
        wait_for(s_req_ready, 1);
        @(negedge clk);
        s_req_valid = 0;
        s_req = ~s_req;
        s_rsp_ready = 1;
        wait_for(s_rsp_valid, 1);
        r = s_rsp;
        @(negedge clk);
        s_rsp_ready = 0;
    endtask
    task automatic t_fwd;
        xfer(1, 32'h0000_0010, 32'hA5C3_0F96);
        chk("wr resp", r.resp, RESP_OKAY);
        xfer(0, 32'h0000_0010, 32'h0);
        chk("rd data", r.rdata, 32'hA5C3_0F96);
        $display("test fwd done");
    endtask
    task automatic t_pdn;
        pdn_req = 1;
        wait_for(pdn_ack, 1);
        f0 = fwd;
        xfer(0, 32'h0000_0010, 32'h0);
        chk("rej resp", r.resp, RESP_SLVERR);
        chk("rej data", r.rdata, 32'h0);
        chk("rej fwd", fwd, f0);
        wait_for(pdn_ack, 1);
        pdn_req = 0;
        wait_for(pdn_ack, 0);
        xfer(0, 32'h0000_0010, 32'h0);
        chk("resume", r, {32'hA5C3_0F96, RESP_OKAY});
        $display("test pdn done");
    endtask
    task automatic t_open;
        lat = 30;
        fork
            xfer(1, 32'h0000_0020, 32'h1234_5678);
            begin
                repeat (6) @(negedge clk);
                pdn_req = 1;
                repeat (12) @(negedge clk);
                chk("ack early", pdn_ack, 1'b0);
            end
        join
        chk("open resp", r.resp, RESP_OKAY);
        wait_for(pdn_ack, 1);
        pdn_req = 0;
        wait_for(pdn_ack, 0);
        lat = 1;
        $display("test open done");
    endtask
    task automatic t_half;
        @(negedge clk);
        m_reset_n = 0;
        repeat (6) @(negedge clk);
        m_reset_n = 1;
        repeat (6) @(negedge clk);
        xfer(0, 32'h0000_0020, 32'h0);
        chk("half rst", r, {32'h1234_5678, RESP_OKAY});
        $display("test half done");
    endtask
    // request withdrawn before ack must not lock the bridge
    task automatic t_early;
        @(negedge clk);
        pdn_req = 1;
        @(negedge clk);
        pdn_req = 0;
        wait_for(pdn_ack, 1);
        wait_for(pdn_ack, 0);
        xfer(0, 32'h0000_0020, 32'h0);
        chk("early resume", r, {32'h1234_5678, RESP_OKAY});
        $display("test early done");
    endtask
    // reset, scenarios, verdict
    initial begin
        {reset_n, m_reset_n, pdn_req, s_req_valid, s_rsp_ready} = '0;
        s_req = '0;
        errors = 0;
        samples_checked = 0;
        fwd = 0;
        lat = 1;
        repeat (20) @(negedge clk);
        {reset_n, m_reset_n} = 2'h3;
        t_fwd();
        t_pdn();
        t_open();
        t_half();
        t_early();
        close_out();
    end
endmodule
